// >>> umh_modem_pins.sv
// modem handshake pins with a classic wishbone register slave
`default_nettype none

module umh_modem_pins (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  // modem pins
  output logic req_to_send_port_one_n_o,
  output logic terminal_ready_out_n_o,
  input wire logic clear_to_send_in_n_i,
  input wire logic req_to_send_port_two_n_i,
  output logic req_to_send_port_two_n_o,
  output logic req_to_send_port_two_oe_n_o,
  output logic [11:0] config_base_strap_o,
  // serial data pins
  input wire logic port_one_receive_in_i,
  output logic port_one_transmit_out_o,
  input wire logic port_two_receive_or_infrared_in_i,
  output logic port_two_transmit_or_infrared_out_o,
  // user side, towards the serial and infrared engines
  input wire logic port_one_txd_i,
  input wire logic port_two_txd_i,
  input wire logic infrared_txd_i,
  output logic port_one_rxd_o,
  output logic port_two_rxd_o,
  output logic infrared_rxd_o
);

  logic [7:0] modem_control_reg;
  logic [7:0] port_two_ctrl_reg;
  logic [7:0] int_en_reg;
  logic [7:0] int_stat_reg;
  logic [7:0] int_stat_next;
  logic delta_cts_reg;
  logic delta_cts_next;
  logic cts_prev_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic strap_done_reg;
  logic strap_bit_reg;
  logic [11:0] cfg_base_reg;
  logic rts1_n_reg;
  logic dtr_n_reg;
  logic rts2_n_reg;
  logic rts2_oe_n_reg;
  logic irq_reg;
  logic tx1_reg;
  logic tx2_reg;
  logic rx1_reg;
  logic rx2_reg;
  logic irx_reg;

  // synchronised pins: {cts_n, rts2_n, rx1, rx2}
  logic [3:0] pins_s;
  umh_sync2 #(.W(4)) u_sync (
    .clk_i(clk_i),
    .async_i({clear_to_send_in_n_i, req_to_send_port_two_n_i,
              port_one_receive_in_i, port_two_receive_or_infrared_in_i}),
    .sync_o(pins_s)
  );

  wire cts_n_s = pins_s[3];
  wire rts2_s = pins_s[2];
  wire rx1_s = pins_s[1];
  wire rx2_s = pins_s[0];

  // bus decode
  wire req = cyc_i & stb_i;
  wire take = req & ~ack_reg;
  wire commit_wr = req & ack_reg & we_i & sel_i[0];
  wire hit_mcr = (adr_i == umh_pkg::OFF_MODEM_CTRL);
  wire hit_msr = (adr_i == umh_pkg::OFF_MODEM_STAT);
  wire hit_ien = (adr_i == umh_pkg::OFF_INT_EN);
  wire hit_ist = (adr_i == umh_pkg::OFF_INT_STAT);
  wire hit_icl = (adr_i == umh_pkg::OFF_INT_CLR);
  wire hit_p2 = (adr_i == umh_pkg::OFF_PORT_TWO_CTRL);
  wire hit_cfg = (adr_i == umh_pkg::OFF_CONFIG);
  wire msr_read = take & ~we_i & hit_msr;
  wire [7:0] clr_mask = (commit_wr & hit_icl) ? dat_i[7:0] : 8'h00;

  wire loop1 = modem_control_reg[umh_pkg::MCR_LOOP_BIT];
  wire loop2 = port_two_ctrl_reg[umh_pkg::MCR_LOOP_BIT];
  wire ir_sel = port_two_ctrl_reg[umh_pkg::MCR_IR_SEL_BIT];

  // modem status view
  wire cts_rise = cts_n_s & ~cts_prev_reg;
  wire cts_change = cts_n_s ^ cts_prev_reg;
  wire [7:0] msr_view = {3'h0, ~cts_n_s, 3'h0, delta_cts_reg}; // R7

  // set wins over the read clear
  assign delta_cts_next = cts_rise | (delta_cts_reg & ~msr_read); // R8 R12

  // set wins over the software clear
  wire [7:0] int_set = {4'h0, cts_change, 3'h0};
  assign int_stat_next = int_set | (int_stat_reg & ~clr_mask);

  wire [7:0] rd_mux = hit_mcr ? modem_control_reg :
                      hit_msr ? msr_view :
                      hit_ien ? int_en_reg :
                      hit_ist ? int_stat_reg :
                      hit_p2 ? port_two_ctrl_reg : 8'h00;
  wire [31:0] rd_word = hit_cfg ? {20'h00000, cfg_base_reg} : {24'h000000, rd_mux};

  wire rts1_n_next = ~(modem_control_reg[umh_pkg::MCR_RTS_BIT] & ~loop1); // R1 R5
  wire dtr_n_next = ~(modem_control_reg[umh_pkg::MCR_DTR_BIT] & ~loop1); // R3 R5
  wire rts2_n_next = ~(port_two_ctrl_reg[umh_pkg::MCR_RTS_BIT] & ~loop2); // R5

  // bus slave: ack one cycle after the request, write at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= take;
      dat_reg <= (take & ~we_i) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      modem_control_reg <= umh_pkg::MCR_RESET;
      port_two_ctrl_reg <= umh_pkg::MCR_RESET;
      int_en_reg <= umh_pkg::INT_EN_RESET;
    end else begin
      if (commit_wr & hit_mcr) begin
        modem_control_reg <= dat_i[7:0];
      end
      if (commit_wr & hit_p2) begin
        port_two_ctrl_reg <= dat_i[7:0];
      end
      if (commit_wr & hit_ien) begin
        int_en_reg <= dat_i[7:0];
      end
    end
  end

  // change detection and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delta_cts_reg <= 1'b0;
      int_stat_reg <= umh_pkg::INT_STAT_RESET;
      irq_reg <= 1'b0;
    end else begin
      delta_cts_reg <= delta_cts_next;
      int_stat_reg <= int_stat_next;
      irq_reg <= |(int_stat_reg & int_en_reg); // R9
    end
  end

  // tracks the pin through reset so no change is flagged at release
  always_ff @(posedge clk_i) begin
    cts_prev_reg <= cts_n_s;
  end

  // strap capture on the first clock after reset release, then drive the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_reg <= 1'b0;
      rts2_oe_n_reg <= 1'b1;
      rts2_n_reg <= 1'b1;
    end else begin
      if (~strap_done_reg) begin
        strap_done_reg <= 1'b1;
        rts2_oe_n_reg <= 1'b0;
      end
      rts2_n_reg <= rts2_n_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (~rst_i & ~strap_done_reg) begin
      strap_bit_reg <= rts2_s; // R6
      cfg_base_reg <= rts2_s ? umh_pkg::CFG_BASE_STRAP_HIGH
                             : umh_pkg::CFG_BASE_STRAP_LOW; // R6
    end
  end

  // handshake outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts1_n_reg <= 1'b1; // R2
      dtr_n_reg <= 1'b1; // R4
    end else begin
      rts1_n_reg <= rts1_n_next; // R1
      dtr_n_reg <= dtr_n_next; // R3
    end
  end

  // data paths: clear-to-send plays no part here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx1_reg <= 1'b1;
      tx2_reg <= 1'b1;
      rx1_reg <= 1'b1;
      rx2_reg <= 1'b1;
      irx_reg <= 1'b1;
    end else begin
      tx1_reg <= loop1 ? 1'b1 : port_one_txd_i; // R10
      tx2_reg <= ir_sel ? infrared_txd_i : port_two_txd_i; // R11
      rx1_reg <= loop1 ? port_one_txd_i : rx1_s;
      rx2_reg <= ir_sel ? 1'b1 : rx2_s; // R11
      irx_reg <= ir_sel ? rx2_s : 1'b1; // R11
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign req_to_send_port_one_n_o = rts1_n_reg;
  assign terminal_ready_out_n_o = dtr_n_reg;
  assign req_to_send_port_two_n_o = rts2_n_reg;
  assign req_to_send_port_two_oe_n_o = rts2_oe_n_reg;
  assign config_base_strap_o = cfg_base_reg;
  assign port_one_transmit_out_o = tx1_reg;
  assign port_two_transmit_or_infrared_out_o = tx2_reg;
  assign port_one_rxd_o = rx1_reg;
  assign port_two_rxd_o = rx2_reg;
  assign infrared_rxd_o = irx_reg;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rts_on;
    modem_control_reg[umh_pkg::MCR_RTS_BIT] && !loop1;
  endsequence

  sequence s_cts_flip_enabled;
    cts_change && int_en_reg[umh_pkg::INT_MODEM_BIT];
  endsequence

  AST_RTS_FOLLOWS_MCR: assert property (s_rts_on |=> !req_to_send_port_one_n_o) // R1
    else $error("request-to-send not asserted from control bit");
  AST_RTS_RESET_HIGH: assert property ($past(rst_i) |-> req_to_send_port_one_n_o) // R2
    else $error("request-to-send not high after reset");
  AST_DTR_FOLLOWS_MCR: assert property ( // R3
    !loop1 |=> terminal_ready_out_n_o == !$past(modem_control_reg[umh_pkg::MCR_DTR_BIT]))
    else $error("terminal-ready does not follow control bit");
  AST_DTR_RESET_HIGH: assert property ($past(rst_i) |-> terminal_ready_out_n_o) // R4
    else $error("terminal-ready not high after reset");
  AST_LOOP_FORCES_IDLE: assert property ( // R5
    loop1 |=> req_to_send_port_one_n_o && terminal_ready_out_n_o)
    else $error("handshake outputs active in loop mode");
  AST_STRAP_SAMPLE: assert property ( // R6
    $rose(strap_done_reg) |-> strap_bit_reg == $past(rts2_s)
      && config_base_strap_o == ($past(rts2_s) ? umh_pkg::CFG_BASE_STRAP_HIGH
                                               : umh_pkg::CFG_BASE_STRAP_LOW))
    else $error("strap base not taken from pin at release");
  AST_MSR_CTS_READ: assert property (msr_read |=> dat_o[4] == !$past(cts_n_s) && ack_o) // R7
    else $error("status bit 4 is not the complement of the pin");
  AST_DELTA_ON_RISE: assert property ($rose(cts_n_s) |=> delta_cts_reg) // R8
    else $error("rising clear-to-send not flagged");
  AST_IRQ_ON_CHANGE: assert property (s_cts_flip_enabled |-> ##2 irq_o) // R9
    else $error("no interrupt after clear-to-send change");
  AST_TX_INDEPENDENT: assert property (!loop1 |=> port_one_transmit_out_o == $past(port_one_txd_i)) // R10
    else $error("transmit data did not pass through");
  AST_IR_SHARED_TX: assert property (ir_sel |=> port_two_transmit_or_infrared_out_o // R11
    == $past(infrared_txd_i))
    else $error("infrared transmit not on shared pin");
  AST_READ_CLEARS_DELTA: assert property (msr_read && !cts_rise |=> !delta_cts_reg) // R12
    else $error("status read did not clear change bit");

  // port two pin and strap
  sequence s_rts2_on;
    port_two_ctrl_reg[umh_pkg::MCR_RTS_BIT] && !loop2;
  endsequence

  AST_RTS2_FOLLOWS_CTRL: assert property (s_rts2_on |=> !req_to_send_port_two_n_o) // R1
    else $error("port two request-to-send not asserted from control bit");
  AST_LOOP2_FORCES_IDLE: assert property (loop2 |=> req_to_send_port_two_n_o) // R5
    else $error("port two request-to-send active in loop mode");
  AST_STRAP_DRIVES_PIN: assert property (strap_done_reg |-> !req_to_send_port_two_oe_n_o) // R6
    else $error("port two request-to-send not driven after strap capture");
  AST_STRAP_STEADY: assert property (strap_done_reg |=> $stable(config_base_strap_o)) // R6
    else $error("strap base changed after capture");
  AST_IR_SHARED_RX: assert property (ir_sel |=> infrared_rxd_o == $past(rx2_s)) // R11
    else $error("infrared receive not taken from shared pin");
  AST_TX2_SERIAL: assert property (!ir_sel |=> port_two_transmit_or_infrared_out_o // R11
    == $past(port_two_txd_i))
    else $error("port two transmit not on shared pin");

  // interrupt, change flag and bus handshake
  AST_IRQ_LEVEL: assert property ((|(int_stat_reg & int_en_reg)) |=> irq_o) // R9
    else $error("interrupt low while an enabled status bit is set");
  AST_IRQ_LOW_WHEN_MASKED: assert property (!(|(int_stat_reg & int_en_reg)) |=> !irq_o) // R9
    else $error("interrupt high with no enabled status bit");
  AST_DELTA_STICKY: assert property (delta_cts_reg && !msr_read |=> delta_cts_reg) // R8
    else $error("change bit lost without a status read");
  AST_ACK_ONE_CYCLE: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held longer than one cycle");
  AST_DAT_ZERO_IDLE: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data not zero outside the acknowledge cycle");

endmodule

`default_nettype wire

// >>> umh_pkg.sv
// package: register map, field positions and reset values of the modem handshake block
//
// Notes on behaviour
// R1 - port request-to-send pin, active low, follows modem control bit 1.
// R2 - reset leaves request-to-send high, inactive.
// R3 - data-terminal-ready pin, active low, follows modem control bit 0.
// R4 - reset leaves data-terminal-ready high, inactive.
// R5 - loop mode forces request-to-send and data-terminal-ready inactive.
// R6 - port two request-to-send sampled at reset release: 0 gives 3f0, 1 gives 370.
// R7 - modem status bit 4 reads the complement of the clear-to-send pin.
// R8 - clear-to-send pin rising since last status read sets modem status bit 0.
// R9 - interrupt enable bit 3 lets a clear-to-send change raise the interrupt.
// R10 - transmit data never waits on or is gated by clear-to-send.
// R11 - port two receive and transmit pins double as infrared receive and transmit.
// R12 - reading modem status clears its change indicator bits.
`default_nettype none

package umh_pkg;

  // byte offsets on the bus, one aligned word each
  localparam logic [4:0] OFF_MODEM_CTRL = 5'h00;
  localparam logic [4:0] OFF_MODEM_STAT = 5'h04;
  localparam logic [4:0] OFF_INT_EN = 5'h08;
  localparam logic [4:0] OFF_INT_STAT = 5'h0c;
  localparam logic [4:0] OFF_INT_CLR = 5'h10;
  localparam logic [4:0] OFF_PORT_TWO_CTRL = 5'h14;
  localparam logic [4:0] OFF_CONFIG = 5'h18;

  // modem control fields (both ports share the layout)
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_IR_SEL_BIT = 6;

  // modem status fields
  localparam int MSR_DELTA_CTS_BIT = 0;
  localparam int MSR_CTS_BIT = 4;

  // interrupt status, clear and enable share this layout
  localparam int INT_MODEM_BIT = 3;

  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] INT_EN_RESET = 8'h00;
  localparam logic [7:0] INT_STAT_RESET = 8'h00;

  // configuration index base chosen by the strap
  localparam logic [11:0] CFG_BASE_STRAP_LOW = 12'h3f0;
  localparam logic [11:0] CFG_BASE_STRAP_HIGH = 12'h370;

endpackage

`default_nettype wire

// >>> umh_sync2.sv
// two-stage synchroniser for asynchronous pin inputs
`default_nettype none

module umh_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // no reset, so the pins are tracked through reset and a strap is valid at release
  always_ff @(posedge clk_i) begin
    meta_reg <= async_i;
    sync_o <= meta_reg;
  end

endmodule

`default_nettype wire

// >>> umh_modem_model.sv
// modem side model: clear-to-send source and strap resistor on port two rts
`default_nettype none

module umh_modem_model (
  input wire logic cts_active_i,
  input wire logic strap_i,
  input wire logic rts2_i,
  input wire logic rts2_oe_n_i,
  output logic cts_n_o,
  output logic rts2_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign cts_n_o = ~cts_active_i;
  // the strap resistor only sets the level while the device releases the pin
  assign rts2_pin_o = rts2_oe_n_i ? strap_i : rts2_i;
endmodule

`default_nettype wire

// >>> umh_modem_pins_tb.sv
// testbench of the modem handshake pins block
`default_nettype none

module umh_modem_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, cts_act, strap, rts2_pin, cts_n, rx1, rx2;
  logic ack, irq, rts1_n, dtr_n, rts2_o, rts2_oe_n, tx1, tx2, tx1_d, tx2_d, ir_d;
  logic rx1_d, rx2_d, ir_rx;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd, dat;
  logic [11:0] base;
  int fails = 0;
  int total_checks = 0;
  umh_modem_pins umh_modem_pins_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dat),
    .ack_o(ack), .irq_o(irq), .req_to_send_port_one_n_o(rts1_n),
    .terminal_ready_out_n_o(dtr_n), .clear_to_send_in_n_i(cts_n),
    .req_to_send_port_two_n_i(rts2_pin), .req_to_send_port_two_n_o(rts2_o),
    .req_to_send_port_two_oe_n_o(rts2_oe_n), .config_base_strap_o(base),
    .port_one_receive_in_i(rx1), .port_one_transmit_out_o(tx1),
    .port_two_receive_or_infrared_in_i(rx2), .port_two_transmit_or_infrared_out_o(tx2),
    .port_one_txd_i(tx1_d), .port_two_txd_i(tx2_d), .infrared_txd_i(ir_d),
    .port_one_rxd_o(rx1_d), .port_two_rxd_o(rx2_d), .infrared_rxd_o(ir_rx));
  umh_modem_model umh_modem_model_inst (.cts_active_i(cts_act), .strap_i(strap),
    .rts2_i(rts2_o), .rts2_oe_n_i(rts2_oe_n), .cts_n_o(cts_n), .rts2_pin_o(rts2_pin));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; waits for ack and takes read data at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic t_reset(input logic s, input logic [11:0] b);
    @(posedge clk_i);
    strap <= s;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("rts dtr idle", 32'h3, {30'h0, rts1_n, dtr_n});
    chk("base", {20'h0, b}, {20'h0, base});
    chk("rts2 oe pin", 32'h1, {30'h0, rts2_oe_n, rts2_o});
    rdchk("config", umh_pkg::OFF_CONFIG, {20'h0, b});
  endtask

  task automatic t_mcr;
    logic [7:0] v;
    tx1_d <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? 8'h13 : 8'(i);
      bus(1'b1, umh_pkg::OFF_MODEM_CTRL, {24'h0, v});
      repeat (2) @(posedge clk_i);
      chk("rts dtr", {30'h0, ~(v[1] & ~v[4]), ~(v[0] & ~v[4])}, {30'h0, rts1_n, dtr_n});
    end
    chk("loop data", 32'h2, {30'h0, tx1, rx1_d});
    rdchk("mcr", umh_pkg::OFF_MODEM_CTRL, 32'h13);
    bus(1'b1, umh_pkg::OFF_MODEM_CTRL, 32'h0);
    sel <= 4'he;
    bus(1'b1, umh_pkg::OFF_MODEM_CTRL, 32'h03);
    sel <= 4'hf;
    rdchk("mcr sel", umh_pkg::OFF_MODEM_CTRL, 32'h0);
  endtask

  task automatic t_cts;
    bus(1'b1, umh_pkg::OFF_INT_EN, 32'h08);
    bus(1'b1, umh_pkg::OFF_INT_CLR, 32'h08);
    bus(1'b0, umh_pkg::OFF_MODEM_STAT, 32'h0);
    cts_act <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("irq fall", 32'h1, {31'h0, irq});
    rdchk("msr fall", umh_pkg::OFF_MODEM_STAT, 32'h10);
    bus(1'b1, umh_pkg::OFF_INT_CLR, 32'h08);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
    cts_act <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("irq rise", 32'h1, {31'h0, irq});
    rdchk("msr rise", umh_pkg::OFF_MODEM_STAT, 32'h01);
    rdchk("msr reread", umh_pkg::OFF_MODEM_STAT, 32'h00);
    bus(1'b1, umh_pkg::OFF_INT_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk("int stat", umh_pkg::OFF_INT_STAT, 32'h08);
    bus(1'b1, umh_pkg::OFF_INT_CLR, 32'h08);
    rdchk("int stat clr", umh_pkg::OFF_INT_STAT, 32'h0);
    rdchk("int clr", umh_pkg::OFF_INT_CLR, 32'h0);
    rdchk("unmapped", 5'h1c, 32'h0);
    bus(1'b1, umh_pkg::OFF_MODEM_STAT, 32'hff);
    rdchk("msr ro", umh_pkg::OFF_MODEM_STAT, 32'h0);
  endtask

  task automatic t_data;
    bus(1'b1, umh_pkg::OFF_PORT_TWO_CTRL, 32'h40);
    tx1_d <= 1'b0;
    ir_d <= 1'b0;
    rx1 <= 1'b0;
    rx2 <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("tx ir", 32'h0, {29'h0, tx1, tx2, rx1_d});
    chk("rx ir", 32'h1, {30'h0, ir_rx, rx2_d});
    bus(1'b1, umh_pkg::OFF_PORT_TWO_CTRL, 32'h0);
    cts_act <= 1'b1;
    tx1_d <= 1'b1;
    tx2_d <= 1'b0;
    ir_d <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("tx serial", 32'h2, {30'h0, tx1, tx2});
    chk("rx serial", 32'h2, {30'h0, ir_rx, rx2_d});
    bus(1'b1, umh_pkg::OFF_PORT_TWO_CTRL, 32'h02);
    repeat (2) @(posedge clk_i);
    chk("rts2 on", 32'h0, {31'h0, rts2_o});
    bus(1'b1, umh_pkg::OFF_PORT_TWO_CTRL, 32'h12);
    repeat (2) @(posedge clk_i);
    chk("rts2 loop", 32'h1, {31'h0, rts2_o});
    bus(1'b1, umh_pkg::OFF_PORT_TWO_CTRL, 32'h0);
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'hf;
    wd = 32'h0;
    cts_act = 1'b0;
    strap = 1'b0;
    {rx1, rx2, tx1_d, tx2_d, ir_d} = 5'h1f;
    t_reset(1'b0, 12'h3f0);
    t_cts;
    t_mcr;
    t_data;
    t_reset(1'b1, 12'h370);
    test_done;
  end

  initial begin
    #300000;
    fails++;
    test_done;
  end
endmodule

`default_nettype wire
